// *** common/drts_pkg.sv ***
// Purpose: Constants for the drive trip-retry and start supervisor
// Assumes: 10 MHz control clock, settings held in tenths of a second
// Notes:   Register offsets are byte addresses on AXI4-Lite
package drts_pkg;
	// ==================================================================
	// Timing
	localparam int CLK_PERIOD_NS    = 100;
	localparam int TENTH_NS         = 100_000_000;
	localparam int TENTH_CYCLES     = TENTH_NS / CLK_PERIOD_NS;
	localparam int FAN_MIN_MINUTES  = 10;
	localparam int FAN_MIN_TENTHS   = FAN_MIN_MINUTES * 600;
	localparam int SEARCH_MAX_MS    = 1200;
	localparam int SEARCH_MAX_TENTHS = SEARCH_MAX_MS / 100;
	// ==================================================================
	// Setting ranges, in tenths of a second or counts
	localparam logic [3:0] RETRY_MAX      = 4'hA;
	localparam logic [7:0] INTERVAL_MIN   = 8'h05;
	localparam logic [7:0] INTERVAL_MAX   = 8'hC8;
	localparam logic [7:0] DLY_RUN_MAX    = 8'h64;
	localparam logic [7:0] DLY_RST_MIN    = 8'h01;
	localparam logic [7:0] DLY_RST_MAX    = 8'h64;
	// ==================================================================
	// Register offsets
	localparam logic [7:0] CFG_OFS      = 8'h00;
	localparam logic [7:0] TIME_OFS     = 8'h04;
	localparam logic [7:0] STAT_OFS     = 8'h08;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
	localparam logic [7:0] IRQ_EN_OFS   = 8'h10;
	localparam logic [7:0] IRQ_CLR_OFS  = 8'h14;
	// ==================================================================
	// Field positions of the configuration register
	localparam int CFG_RETRY_LSB = 0;
	localparam int CFG_FAN_BIT   = 4;
	localparam int CFG_DIR_LSB   = 5;
	localparam int CFG_MVF_LSB   = 7;
	localparam int CFG_MVEC_LSB  = 9;
	localparam int CFG_DRV_LSB   = 11;
	localparam int CFG_PFR_LSB   = 14;
	localparam int CFG_STMA_BIT  = 17;
	localparam int TIME_INT_LSB  = 0;
	localparam int TIME_RUN_LSB  = 8;
	localparam int TIME_RST_LSB  = 16;
	// ==================================================================
	// Reset values
	localparam logic [31:0] CFG_RESET  = 32'h0000_0400;
	localparam logic [31:0] TIME_RESET = 32'h0001_0005;
	// ==================================================================
	// Encodings
	localparam logic [1:0] DIR_NONE   = 2'h0;
	localparam logic [1:0] DIR_NO_REV = 2'h1;
	localparam logic [1:0] DIR_NO_FWD = 2'h2;
	localparam logic [1:0] MODE_OFF   = 2'h0;
	localparam logic [1:0] MODE_BOTH  = 2'h2;
	localparam logic [2:0] DRV_VECTOR_SENSOR = 3'h5;
	localparam logic [2:0] PFR_SEARCH_LO = 3'h3;
	localparam logic [2:0] PFR_SEARCH_HI = 3'h5;
	localparam logic [3:0] CAUSE_ELIG_LIMIT = 4'h8;
	localparam int IRQ_TRIP   = 0;
	localparam int IRQ_ALARM  = 1;
	localparam int IRQ_RESET  = 2;
	localparam int IRQ_SEARCH = 3;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [3:0] {
		CAUSE_OVERCURRENT, CAUSE_OVERVOLTAGE, CAUSE_HEATSINK_HOT, CAUSE_INTERNAL_HOT,
		CAUSE_MOTOR_HOT, CAUSE_BRAKE_RES_HOT, CAUSE_MOTOR_OVERLOAD, CAUSE_DRIVE_OVERLOAD,
		CAUSE_OTHER
	} drts_cause_t;
	typedef enum logic [1:0] {R_IDLE, R_WAIT, R_ALARM} drts_retry_t;
	typedef enum logic [1:0] {S_IDLE, S_DELAY, S_SEARCH, S_RUN} drts_seq_t;
endpackage

// *** verilog/drts_supervisor.sv ***
// Contract
// - Eligible trip retries without alarm when count nonzero
// - Exceeding retry count raises alarm, stops retrying
// - Retry count is 0 or 1 to 10
// - Wait retry interval before each reset command
// - Only the eight listed trip causes retry
// - Auto-reset status high while retry in progress
// - Fan control 1 gates fan; 0 always on
// - Fan runs at least 10 minutes once on
// - Fan status follows fan when control enabled
// - Direction limit blocks reverse or forward rotation
// - Unassigned search input reads as off
// - Search enable table from mode and input
// - Mode from vector setting under sensor vector control
// - Search lasts at most 1.2 s, then accelerate
// - Run-command start with search enabled waits first search delay; else none
// - Restart waits second search delay
// Purpose: Trip retry, cooling fan, direction limit and start search sequencing
// Assumes: Pin inputs asynchronous; AXI4-Lite on mclk_i
// Notes:   All timers count tenth-second ticks
`timescale 1ns/100ps
`default_nettype none
module drts_supervisor import drts_pkg::*; #(
	parameter int TENTH_CYC = TENTH_CYCLES
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire logic        trip_i,
	input  wire logic [3:0]  trip_cause_i,
	input  wire logic        manual_reset_i,
	input  wire logic        run_fwd_i,
	input  wire logic        run_rev_i,
	input  wire logic        coast_command_i,
	input  wire logic        search_at_start_input_i,
	input  wire logic        power_restored_i,
	input  wire logic        temp_low_i,
	input  wire logic        search_done_i,
	output logic             run_fwd_o,
	output logic             run_rev_o,
	output logic             search_o,
	output logic             reset_cmd_o,
	output logic             alarm_output_o,
	output logic             auto_reset_active_o,
	output logic             fan_on_o,
	output logic             fan_running_o,
	output logic             irq_o
);
	// ==================================================================
	// Helpers
	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// ==================================================================
	// Pin synchronisers
	localparam int NP = 13;
	logic [NP-1:0] pin_s1_reg;
	logic [NP-1:0] pin_s2_reg;
	logic [NP-1:0] pin_s3_reg;
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
			pin_s3_reg <= '0;
		end else if (ce_i) begin
			pin_s1_reg <= {trip_cause_i, trip_i, manual_reset_i, run_fwd_i, run_rev_i,
				coast_command_i, search_at_start_input_i, power_restored_i, temp_low_i,
				search_done_i};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end
	logic [3:0] cause;
	logic       trip_ev;
	logic       mreset;
	logic       fwd_cmd;
	logic       rev_cmd;
	logic       coast;
	logic       stm_pin;
	logic       pwr_ev;
	logic       temp_low;
	logic       sdone;
	logic       coast_rel;
	assign cause     = pin_s2_reg[12:9];
	assign trip_ev   = pin_s2_reg[8] & ~pin_s3_reg[8];
	assign mreset    = pin_s2_reg[7];
	assign fwd_cmd   = pin_s2_reg[6];
	assign rev_cmd   = pin_s2_reg[5];
	assign coast     = pin_s2_reg[4];
	assign coast_rel = ~pin_s2_reg[4] & pin_s3_reg[4];
	assign stm_pin   = pin_s2_reg[3];
	assign pwr_ev    = pin_s2_reg[2] & ~pin_s3_reg[2];
	assign temp_low  = pin_s2_reg[1];
	assign sdone     = pin_s2_reg[0];

	// ==================================================================
	// Tenth-second tick
	logic [31:0] tick_cnt_reg;
	logic        tick;
	assign tick = (tick_cnt_reg == 32'(TENTH_CYC - 1));
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			tick_cnt_reg <= '0;
		end else if (ce_i) begin
			tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 32'h1;
		end
	end

	// ==================================================================
	// Registers over AXI4-Lite
	logic [31:0] cfg_reg;
	logic [31:0] time_reg;
	logic [3:0]  irq_stat_reg;
	logic [3:0]  irq_en_reg;
	logic [7:0]  awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic        aw_held_reg;
	logic        w_held_reg;
	logic        wr_go;
	logic [31:0] cfg_m;
	logic [31:0] time_m;
	logic [31:0] rd_val;
	logic        rd_hit;
	assign wr_go  = aw_held_reg & w_held_reg & ~s_axi_bvalid_o;
	assign cfg_m  = wmerge(cfg_reg, wdata_reg, wstrb_reg);
	assign time_m = wmerge(time_reg, wdata_reg, wstrb_reg);

	logic [3:0] cfg_retry;
	logic       cfg_fan;
	logic [1:0] cfg_dir;
	logic [1:0] cfg_mvf;
	logic [1:0] cfg_mvec;
	logic [2:0] cfg_drv;
	logic [2:0] cfg_pfr;
	logic       cfg_stma;
	logic [7:0] t_int;
	logic [7:0] t_run;
	logic [7:0] t_rst;
	assign cfg_retry = cfg_reg[CFG_RETRY_LSB +: 4];
	assign cfg_fan   = cfg_reg[CFG_FAN_BIT];
	assign cfg_dir   = cfg_reg[CFG_DIR_LSB +: 2];
	assign cfg_mvf   = cfg_reg[CFG_MVF_LSB +: 2];
	assign cfg_mvec  = cfg_reg[CFG_MVEC_LSB +: 2];
	assign cfg_drv   = cfg_reg[CFG_DRV_LSB +: 3];
	assign cfg_pfr   = cfg_reg[CFG_PFR_LSB +: 3];
	assign cfg_stma  = cfg_reg[CFG_STMA_BIT];
	assign t_int     = time_reg[TIME_INT_LSB +: 8];
	assign t_run     = time_reg[TIME_RUN_LSB +: 8];
	assign t_rst     = time_reg[TIME_RST_LSB +: 8];

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= RESP_OKAY;
			aw_held_reg     <= 1'b0;
			w_held_reg      <= 1'b0;
			awaddr_reg      <= '0;
			wdata_reg       <= '0;
			wstrb_reg       <= '0;
		end else if (ce_i) begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				awaddr_reg      <= s_axi_awaddr_i;
				aw_held_reg     <= 1'b1;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				wdata_reg      <= s_axi_wdata_i;
				wstrb_reg      <= s_axi_wstrb_i;
				w_held_reg     <= 1'b1;
				s_axi_wready_o <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= (awaddr_reg == CFG_OFS || awaddr_reg == TIME_OFS ||
					awaddr_reg == IRQ_EN_OFS || awaddr_reg == IRQ_CLR_OFS) ?
					RESP_OKAY : RESP_SLVERR;
				aw_held_reg    <= 1'b0;
				w_held_reg     <= 1'b0;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o  <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			cfg_reg    <= CFG_RESET;
			time_reg   <= TIME_RESET;
			irq_en_reg <= '0;
		end else if (ce_i && wr_go) begin
			if (awaddr_reg == CFG_OFS) begin
				cfg_reg <= {14'h0, cfg_m[17:4],
					(cfg_m[3:0] > RETRY_MAX) ? RETRY_MAX : cfg_m[3:0]};
			end
			if (awaddr_reg == TIME_OFS) begin
				time_reg <= {8'h0, clamp8(time_m[23:16], DLY_RST_MIN, DLY_RST_MAX),
					clamp8(time_m[15:8], 8'h00, DLY_RUN_MAX),
					clamp8(time_m[7:0], INTERVAL_MIN, INTERVAL_MAX)};
			end
			if (awaddr_reg == IRQ_EN_OFS && wstrb_reg[0]) begin
				irq_en_reg <= wdata_reg[3:0];
			end
		end
	end

	// ==================================================================
	// Retry sequencer
	drts_retry_t rstate_reg;
	drts_retry_t rstate_next;
	drts_seq_t   sstate_reg;
	drts_seq_t   sstate_next;
	logic [7:0]  rtim_reg;
	logic [3:0]  retry_cnt_reg;
	logic        elig;
	assign elig = (cause < CAUSE_ELIG_LIMIT);

	always_comb begin
		rstate_next = rstate_reg;
		case (rstate_reg)
			R_IDLE: begin
				if (trip_ev) begin
					if (elig && cfg_retry != 4'h0 && retry_cnt_reg < cfg_retry) begin
						rstate_next = R_WAIT;
					end else begin
						rstate_next = R_ALARM;
					end
				end
			end
			R_WAIT: begin
				if (rtim_reg >= t_int) begin
					rstate_next = R_IDLE;
				end
			end
			R_ALARM: rstate_next = R_ALARM;
			default: rstate_next = R_IDLE;
		endcase
		if (mreset) begin
			rstate_next = R_IDLE;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			rstate_reg          <= R_IDLE;
			rtim_reg            <= '0;
			retry_cnt_reg       <= '0;
			reset_cmd_o         <= 1'b0;
			alarm_output_o      <= 1'b0;
			auto_reset_active_o <= 1'b0;
		end else if (ce_i) begin
			rstate_reg     <= rstate_next;
			alarm_output_o <= (rstate_next == R_ALARM);
			reset_cmd_o    <= (rstate_reg == R_WAIT) && (rstate_next == R_IDLE) && !mreset;
			if (rstate_next != R_WAIT) begin
				rtim_reg <= '0;
			end else if (tick && rtim_reg != 8'hFF) begin
				rtim_reg <= rtim_reg + 8'h1;
			end
			if (mreset) begin
				retry_cnt_reg <= '0;
			end else if (rstate_reg == R_WAIT && rstate_next == R_IDLE) begin
				retry_cnt_reg <= retry_cnt_reg + 4'h1;
			end
			if (rstate_next == R_WAIT) begin
				auto_reset_active_o <= 1'b1;
			end else if (rstate_next == R_ALARM || mreset || sstate_reg == S_RUN) begin
				auto_reset_active_o <= 1'b0;
			end
		end
	end

	// ==================================================================
	// Start sequencer with idling-speed search
	logic       search_at_start_input;
	logic [1:0] smode;
	logic       en_restart;
	logic       en_normal;
	logic       run_req;
	logic       restart_pend_reg;
	logic       sen_reg;
	logic [7:0] slim_reg;
	logic [7:0] stim_reg;
	logic       stop_cond;
	logic       restart_ev;
	logic       restart;
	assign restart_ev = (pwr_ev && cfg_pfr >= PFR_SEARCH_LO && cfg_pfr <= PFR_SEARCH_HI) ||
		coast_rel || reset_cmd_o;
	// Restart event may land in the same cycle as the start request
	assign restart    = restart_pend_reg | restart_ev;
	assign search_at_start_input        = cfg_stma & stm_pin;
	assign smode      = (cfg_drv == DRV_VECTOR_SENSOR) ? cfg_mvec : cfg_mvf;
	assign en_restart = search_at_start_input || smode != MODE_OFF;
	assign en_normal  = search_at_start_input || smode == MODE_BOTH;
	assign run_req    = fwd_cmd | rev_cmd;
	assign stop_cond  = !run_req || coast || rstate_reg != R_IDLE;

	always_comb begin
		sstate_next = sstate_reg;
		case (sstate_reg)
			S_IDLE: begin
				if (!stop_cond) begin
					sstate_next = S_DELAY;
				end
			end
			S_DELAY: begin
				if (stim_reg >= slim_reg) begin
					sstate_next = sen_reg ? S_SEARCH : S_RUN;
				end
			end
			S_SEARCH: begin
				if (sdone || stim_reg >= 8'(SEARCH_MAX_TENTHS)) begin
					sstate_next = S_RUN;
				end
			end
			S_RUN: sstate_next = S_RUN;
			default: sstate_next = S_IDLE;
		endcase
		if (stop_cond) begin
			sstate_next = S_IDLE;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			sstate_reg       <= S_IDLE;
			stim_reg         <= '0;
			sen_reg          <= 1'b0;
			slim_reg         <= '0;
			restart_pend_reg <= 1'b0;
			search_o         <= 1'b0;
		end else if (ce_i) begin
			sstate_reg <= sstate_next;
			search_o   <= (sstate_next == S_SEARCH);
			if (sstate_next != sstate_reg) begin
				stim_reg <= '0;
			end else if (tick && stim_reg != 8'hFF) begin
				stim_reg <= stim_reg + 8'h1;
			end
			if (sstate_reg == S_IDLE && sstate_next == S_DELAY) begin
				restart_pend_reg <= 1'b0;
				sen_reg          <= restart ? en_restart : en_normal;
				slim_reg         <= restart ? t_rst : (en_normal ? t_run : 8'h00);
			end else if (restart_ev) begin
				restart_pend_reg <= 1'b1;
			end
		end
	end

	// ==================================================================
	// Run outputs with direction limit
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			run_fwd_o <= 1'b0;
			run_rev_o <= 1'b0;
		end else if (ce_i) begin
			run_fwd_o <= (sstate_next == S_RUN) && fwd_cmd && cfg_dir != DIR_NO_FWD;
			run_rev_o <= (sstate_next == S_RUN) && rev_cmd && !fwd_cmd &&
				cfg_dir != DIR_NO_REV;
		end
	end

	// ==================================================================
	// Cooling fan
	logic [12:0] fan_cnt_reg;
	logic        fan_next;
	always_comb begin
		if (!cfg_fan) begin
			fan_next = 1'b1;
		end else if (sstate_reg != S_IDLE || !temp_low) begin
			fan_next = 1'b1;
		end else begin
			fan_next = fan_on_o && fan_cnt_reg < 13'(FAN_MIN_TENTHS);
		end
	end
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			fan_on_o      <= 1'b0;
			fan_running_o <= 1'b0;
			fan_cnt_reg   <= '0;
		end else if (ce_i) begin
			fan_on_o      <= fan_next;
			fan_running_o <= fan_next & cfg_fan;
			if (!fan_on_o) begin
				fan_cnt_reg <= '0;
			end else if (tick && fan_cnt_reg < 13'(FAN_MIN_TENTHS)) begin
				fan_cnt_reg <= fan_cnt_reg + 13'h1;
			end
		end
	end

	// ==================================================================
	// Interrupts and read path
	logic [3:0] irq_ev;
	logic [3:0] irq_clr;
	logic [3:0] irq_stat_next;
	assign irq_ev = {sstate_reg == S_SEARCH && sstate_next == S_RUN, reset_cmd_o,
		rstate_next == R_ALARM && rstate_reg != R_ALARM, trip_ev};
	assign irq_clr = (wr_go && awaddr_reg == IRQ_CLR_OFS && wstrb_reg[0]) ?
		wdata_reg[3:0] : 4'h0;
	assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_ev;
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			irq_stat_reg <= '0;
			irq_o        <= 1'b0;
		end else if (ce_i) begin
			irq_stat_reg <= irq_stat_next;
			irq_o        <= |(irq_stat_next & irq_en_reg);
		end
	end

	always_comb begin
		rd_hit = 1'b1;
		case (s_axi_araddr_i)
			CFG_OFS:      rd_val = cfg_reg;
			TIME_OFS:     rd_val = time_reg;
			STAT_OFS:     rd_val = {23'h0, sstate_reg == S_RUN, search_o, fan_on_o,
				auto_reset_active_o, alarm_output_o, retry_cnt_reg};
			IRQ_STAT_OFS: rd_val = {28'h0, irq_stat_reg};
			IRQ_EN_OFS:   rd_val = {28'h0, irq_en_reg};
			IRQ_CLR_OFS:  rd_val = 32'h0;
			default: begin
				rd_val = 32'h0;
				rd_hit = 1'b0;
			end
		endcase
	end
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= '0;
			s_axi_rresp_o   <= RESP_OKAY;
		end else if (ce_i) begin
			if (s_axi_arvalid_i && s_axi_arready_o) begin
				s_axi_arready_o <= 1'b0;
				s_axi_rvalid_o  <= 1'b1;
				s_axi_rdata_o   <= rd_val;
				s_axi_rresp_o   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid_o && s_axi_rready_i) begin
				s_axi_rvalid_o  <= 1'b0;
				s_axi_arready_o <= 1'b1;
			end
		end
	end

	// ==================================================================
	// Assertions
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	zero_count_alarm_a: assert property (ce_i && rstate_reg == R_IDLE && trip_ev &&
		cfg_retry == 4'h0 && !mreset |=> alarm_output_o) else $error("no alarm at count 0");
	retry_no_alarm_a: assert property (ce_i && rstate_reg == R_IDLE && trip_ev && elig &&
		retry_cnt_reg < cfg_retry && !mreset |=> !alarm_output_o && auto_reset_active_o)
		else $error("eligible trip raised alarm");
	exhaust_alarm_a: assert property (ce_i && rstate_reg == R_IDLE && trip_ev &&
		retry_cnt_reg >= cfg_retry && !mreset |=> alarm_output_o && !auto_reset_active_o)
		else $error("exhausted retry without alarm");
	inelig_alarm_a: assert property (ce_i && rstate_reg == R_IDLE && trip_ev && !elig &&
		!mreset |=> rstate_reg == R_ALARM) else $error("ineligible trip retried");
	count_step_a: assert property (ce_i && rstate_reg == R_WAIT && rstate_next == R_IDLE &&
		!mreset |=> retry_cnt_reg == $past(retry_cnt_reg) + 4'h1)
		else $error("retry counter did not step");
	reset_interval_a: assert property ($rose(reset_cmd_o) |-> $past(rtim_reg) >= t_int)
		else $error("reset before interval");
	busy_in_wait_a: assert property (rstate_reg == R_WAIT && !mreset |=>
		auto_reset_active_o || !$past(ce_i)) else $error("status low during retry wait");
	fan_always_a: assert property (ce_i && !cfg_fan |=> fan_on_o && !fan_running_o)
		else $error("fan off with control disabled");
	fan_min_run_a: assert property ($fell(fan_on_o) |->
		$past(fan_cnt_reg) >= 13'(FAN_MIN_TENTHS)) else $error("fan stopped too early");
	fan_status_a: assert property (ce_i && cfg_fan |=> fan_running_o == fan_on_o)
		else $error("fan status mismatch");
	no_rev_a: assert property ($past(ce_i) && $past(cfg_dir) == DIR_NO_REV |-> !run_rev_o)
		else $error("reverse run while inhibited");
	no_fwd_a: assert property ($past(ce_i) && $past(cfg_dir) == DIR_NO_FWD |-> !run_fwd_o)
		else $error("forward run while inhibited");
	search_len_a: assert property (sstate_reg == S_SEARCH |->
		stim_reg <= 8'(SEARCH_MAX_TENTHS)) else $error("search too long");
	start_delay_a: assert property (sstate_reg == S_DELAY && sstate_next != S_DELAY &&
		!stop_cond |-> stim_reg >= slim_reg) else $error("start before delay");

	cover property ($rose(alarm_output_o));
	cover property ($rose(reset_cmd_o));
	cover property (sstate_reg == S_SEARCH ##1 sstate_reg == S_RUN);
	cover property ($fell(fan_on_o));
endmodule
`default_nettype wire

// *** tb/drts_motor_model.sv ***
// Purpose: Motor and terminal stand-in for the supervisor bench
// Assumes: Bench holds a trip request for two cycles
// Notes:   Slow mode never reports search done
`timescale 1ns/100ps
`default_nettype none
module drts_motor_model #(
	parameter int LAT = 6
) (
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	input  wire logic       search_i,
	input  wire logic       slow_i,
	input  wire logic       trip_req_i,
	input  wire logic [3:0] cause_req_i,
	output logic            trip_o,
	output logic [3:0]      cause_o,
	output logic            done_o
);
	logic [7:0] cnt_reg;
	always_ff @(posedge mclk_i) begin
		trip_o  <= !rst_i && trip_req_i;
		cnt_reg <= (search_i && !rst_i) ? cnt_reg + 8'h01 : 8'h00;
	end
	// Cause pins wander while no trip is shown
	assign cause_o = trip_o ? cause_req_i : ~cause_req_i;
	assign done_o  = search_i && !slow_i && cnt_reg >= 8'(LAT);
endmodule
`default_nettype wire

// *** tb/drts_supervisor_tb.sv ***
// Purpose: Self-checking bench for the trip-retry and start supervisor
// Assumes: TENTH_CYC of 4 cycles
// Notes:   Power-restore pin stays idle
`timescale 1ns/100ps
`default_nettype none
module drts_supervisor_tb import drts_pkg::*;;
	localparam int TC = 4;
	logic        mclk_i, rst_i, ce_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
	logic        s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o;
	logic        s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, trip_i, manual_reset_i;
	logic        run_fwd_i, run_rev_i, coast_command_i, search_at_start_input_i;
	logic        power_restored_i, temp_low_i, search_done_i, run_fwd_o, run_rev_o;
	logic        search_o, reset_cmd_o, alarm_output_o, auto_reset_active_o, fan_on_o;
	logic        fan_running_o, irq_o, trip_req, slow;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, resp;
	logic [3:0]  s_axi_wstrb_i, trip_cause_i, cause_req;
	logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd;
	int          errors = 0, checked = 0, cyc = 0, n;
	wire logic [4:0] mon = {auto_reset_active_o, alarm_output_o, run_fwd_o, search_o, reset_cmd_o};
	drts_supervisor #(.TENTH_CYC(TC)) u_dut (.*);
	drts_motor_model u_motor (.mclk_i(mclk_i), .rst_i(rst_i), .search_i(search_o),
		.slow_i(slow), .trip_req_i(trip_req), .cause_req_i(cause_req), .trip_o(trip_i),
		.cause_o(trip_cause_i), .done_o(search_done_i));
	// ====================================
	// Clock, timeout and helpers
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			errors++;
			end_of_test();
		end
	end
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
			errors++;
		end
	endtask
	task automatic ok(input logic c);
		chk({31'h0, c}, 32'h1);
	endtask
	// One AXI4-Lite write (w=1) or read (w=0)
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr_i <= a;
		s_axi_araddr_i <= a;
		s_axi_wdata_i <= d;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= {3{w}};
		{s_axi_arvalid_i, s_axi_rready_i} <= {2{!w}};
		forever begin
			@(posedge mclk_i);
			if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
			if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
			rd = s_axi_rdata_o;
			resp = w ? s_axi_bresp_o : s_axi_rresp_o;
			if (w ? s_axi_bvalid_o : s_axi_rvalid_o) break;
		end
		{s_axi_bready_i, s_axi_rready_i} <= 2'b00;
		@(posedge mclk_i);
	endtask
	task automatic wait_sig(input int sel, input int lim);
		for (n = 0; n < lim; n++) begin
			@(posedge mclk_i);
			if (mon[sel] === 1'b1) break;
		end
	endtask
	task automatic do_trip(input logic [3:0] c);
		cause_req <= c;
		trip_req <= 1'b1;
		repeat (2) @(posedge mclk_i);
		trip_req <= 1'b0;
	endtask
	task automatic clr;
		manual_reset_i <= 1'b1;
		repeat (5) @(posedge mclk_i);
		manual_reset_i <= 1'b0;
		repeat (5) @(posedge mclk_i);
	endtask
	// ====================================
	// Scenarios
	initial begin
		{rst_i, ce_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 5'b11000;
		{s_axi_arvalid_i, s_axi_rready_i, manual_reset_i, run_fwd_i, run_rev_i} = 5'h00;
		{coast_command_i, search_at_start_input_i, power_restored_i, temp_low_i} = 4'h0;
		{trip_req, slow, cause_req, s_axi_wstrb_i} = 10'h00F;
		{s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 48'h0;
		repeat (4) @(posedge mclk_i);
		rst_i <= 1'b0;
		xfer(1'b0, CFG_OFS, 32'h0);
		chk(rd, CFG_RESET);
		xfer(1'b0, TIME_OFS, 32'h0);
		chk(rd, TIME_RESET);
		xfer(1'b0, 8'h20, 32'h0);
		chk({rd[29:0], resp}, {30'h0, RESP_SLVERR});
		ok(fan_on_o);
		xfer(1'b1, IRQ_EN_OFS, 32'h3);
		xfer(1'b1, CFG_OFS, 32'h402);
		for (int k = 0; k < 3; k++) begin
			do_trip(k[3:0]);
			wait_sig((k < 2) ? 0 : 3, 40);
			if (k < 2) begin
				ok(n >= 14 && n <= 30);
				ok(!alarm_output_o && auto_reset_active_o);
			end else begin
				ok(n < 8);
			end
		end
		xfer(1'b0, STAT_OFS, 32'h0);
		chk({26'h0, rd[5:0]}, 32'h12);
		ok(irq_o);
		xfer(1'b1, IRQ_CLR_OFS, 32'hF);
		ok(!irq_o);
		xfer(1'b1, STAT_OFS, 32'h0);
		chk({30'h0, resp}, {30'h0, RESP_SLVERR});
		clr();
		ok(!alarm_output_o);
		do_trip(4'h8);
		wait_sig(3, 12);
		ok(n < 12 && !auto_reset_active_o);
		clr();
		do_trip(4'h7);
		wait_sig(4, 12);
		ok(n < 12 && !alarm_output_o);
		clr();
		xfer(1'b1, CFG_OFS, 32'h400);
		do_trip(4'h0);
		wait_sig(3, 12);
		ok(n < 12);
		clr();
		xfer(1'b1, CFG_OFS, 32'h40F);
		xfer(1'b0, CFG_OFS, 32'h0);
		chk(rd, 32'h40A);
		xfer(1'b1, CFG_OFS, 32'h420);
		slow <= 1'b1;
		search_at_start_input_i <= 1'b1;
		run_rev_i <= 1'b1;
		repeat (20) @(posedge mclk_i);
		ok(!run_rev_o);
		run_rev_i <= 1'b0;
		run_fwd_i <= 1'b1;
		wait_sig(2, 40);
		ok(n <= 16);
		xfer(1'b1, CFG_OFS, 32'h440);
		repeat (6) @(posedge mclk_i);
		ok(!run_fwd_o);
		run_fwd_i <= 1'b0;
		xfer(1'b1, TIME_OFS, 32'h0001_0205);
		for (int s = 0; s < 2; s++) begin
			xfer(1'b1, CFG_OFS, s[0] ? 32'h0000_2C00 : 32'h0002_0400);
			slow <= s[0];
			repeat (10) @(posedge mclk_i);
			run_fwd_i <= 1'b1;
			wait_sig(1, 40);
			ok(n >= 6 && n <= 20);
			wait_sig(2, 80);
			ok((s != 0) ? (n >= 40 && n <= 54) : (n <= 14));
			run_fwd_i <= 1'b0;
		end
		xfer(1'b1, TIME_OFS, 32'h0005_0000);
		xfer(1'b1, CFG_OFS, 32'h400);
		coast_command_i <= 1'b1;
		run_fwd_i <= 1'b1;
		repeat (10) @(posedge mclk_i);
		coast_command_i <= 1'b0;
		wait_sig(2, 60);
		ok(n >= 17 && n <= 30);
		run_fwd_i <= 1'b0;
		xfer(1'b1, CFG_OFS, 32'h410);
		temp_low_i <= 1'b1;
		repeat (100) @(posedge mclk_i);
		ok(fan_on_o && fan_running_o);
		repeat (24000) @(posedge mclk_i);
		ok(!fan_on_o && !fan_running_o);
		end_of_test();
	end
endmodule
`default_nettype wire
